// ==== sdas_pkg.sv ====
// package: constants and carrier types for the delta-sigma conversion sequencer
package sdas_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_ST = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MK = 8'h10;
  localparam logic [7:0] ADDR_DIV    = 8'h14;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_MODE_LSB  = 1;
  localparam int CTRL_RES8_BIT  = 3;
  localparam int CTRL_MUX_LSB   = 4;
  localparam int CTRL_RTE_BIT   = 8;

  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_OVR_BIT  = 1;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] DIV_RESET  = 16'h0000_0004;
  localparam logic [1:0]  IRQ_RESET  = 2'b00;

  // ----------------------------------------------------------------
  // decimator and rates
  // ----------------------------------------------------------------
  localparam int PRIME_SAMPLES  = 4;
  localparam int RES_HI_BITS    = 12;
  localparam int RES_LO_BITS    = 8;
  localparam int RATE_HI_KSPS   = 192;
  localparam int RATE_LO_KSPS   = 384;
  localparam int OSR_HI         = 64;
  localparam int OSR_LO         = OSR_HI * RATE_HI_KSPS / RATE_LO_KSPS;
  localparam int ACC_W          = 26;

  // ----------------------------------------------------------------
  // modes and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_MULTI  = 2'b01,
    MODE_CONT   = 2'b10,
    MODE_TURBO  = 2'b11
  } sdas_mode_t;

  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_RUN     = 2'b01,
    ST_WAIT_RD = 2'b10
  } sdas_state_t;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0]  resp;
  } sdas_rdata_t;

endpackage : sdas_pkg

// ==== sdas_seq.sv ====
// sequencer, sinc^4 decimator and AXI4-Lite register slave for the delta-sigma converter
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Summary of operation
// - four modes, started by bit or pulse
// - done sets status, holds until read
// - output depends on last four samples
// - data invalid until fourth post-switch sample
// - single: four conversions, publish fourth
// - single: back to standby after transfer
// - continuous: three-period priming, then every period
// - multi: reset and re-prime between samples
// - multi: next sample starts automatically
// - done routable to interrupt/DMA, or polled
// - 12-bit 192k or 8-bit 384k
// - one-bit stream into sinc^4 words
// ----------------------------------------------------------------
module sdas_seq #(
  parameter int OSR_H = sdas_pkg::OSR_HI,
  parameter int OSR_L = sdas_pkg::OSR_LO
) (
  input  wire  logic        aclk,
  input  wire  logic        aresetn,
  input  wire  logic        mod_bit,
  input  wire  logic        conversion_start_pulse,
  input  wire  logic        dma_read,
  output logic              conversion_done_flag,
  output logic              irq,
  output logic              dma_req,
  output logic [3:0]        mux_sel,
  output logic              conv_reset,
  output logic [11:0]       result_word,
  input  wire  logic [7:0]  s_axi_awaddr,
  input  wire  logic        s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire  logic [31:0] s_axi_wdata,
  input  wire  logic [3:0]  s_axi_wstrb,
  input  wire  logic        s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire  logic        s_axi_bready,
  input  wire  logic [7:0]  s_axi_araddr,
  input  wire  logic        s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire  logic        s_axi_rready
);
  import sdas_pkg::*;

  typedef struct packed {
    sdas_state_t            state;
    logic [31:0]            ctrl;
    logic [15:0]            div;
    logic [1:0]             irq_st;
    logic [1:0]             irq_mk;
    logic [3:0][ACC_W-1:0]  integ;
    logic [3:0][ACC_W-1:0]  comb_d;
    logic [15:0]            osr_cnt;
    logic [2:0]             conv_cnt;
    logic [2:0]             valid_cnt;
    logic [3:0]             mux_sel;
    logic [11:0]            result;
    logic                   done;
    logic                   dma_req;
    logic                   irq;
    logic                   conv_reset;
    logic                   aw_ok;
    logic [7:0]             aw_addr;
    logic                   w_ok;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   bvalid;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic [1:0]             bresp;
  } sdas_st_t;

  sdas_st_t r;
  sdas_st_t next_r;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] v;
    v = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        v[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return v;
  endfunction : merge_bytes

  // full scale is osr^4: drop the bits below the result width and clip the one code above it
  localparam int SH_H = (4 * $clog2(OSR_H) > RES_HI_BITS) ? 4 * $clog2(OSR_H) - RES_HI_BITS : 0;
  localparam int SH_L = (4 * $clog2(OSR_L) > RES_LO_BITS) ? 4 * $clog2(OSR_L) - RES_LO_BITS : 0;
  function automatic logic [11:0] scale_word(input logic [ACC_W-1:0] acc, input int sh,
                                             input int bits);
    logic [ACC_W-1:0] v;
    v = acc >> sh;
    return (v >= (ACC_W'(1) << bits)) ? 12'((ACC_W'(1) << bits) - ACC_W'(1)) : 12'(v);
  endfunction : scale_word

  function automatic logic addr_known(input logic [7:0] a);
    logic k;
    if (a == ADDR_CTRL) begin
      k = 1'b1;
    end else if (a == ADDR_STATUS) begin
      k = 1'b1;
    end else if (a == ADDR_RESULT) begin
      k = 1'b1;
    end else if (a == ADDR_IRQ_ST) begin
      k = 1'b1;
    end else if (a == ADDR_IRQ_MK) begin
      k = 1'b1;
    end else if (a == ADDR_DIV) begin
      k = 1'b1;
    end else begin
      k = 1'b0;
    end
    return k;
  endfunction : addr_known

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  sdas_mode_t  mode;
  logic        res8;
  logic        start_ev;
  logic        sample_tick;
  logic        result_rd;
  logic        do_wr;
  logic        do_rd;
  logic        mux_change;
  logic        publish;
  logic [15:0] osr_now;
  logic [ACC_W-1:0] c0;
  logic [ACC_W-1:0] c1;
  logic [ACC_W-1:0] c2;
  logic [ACC_W-1:0] c3;
  logic [31:0] wval;
  logic [1:0]  done_ev;

  always_comb begin
    next_r      = r;
    mode        = sdas_mode_t'(r.ctrl[CTRL_MODE_LSB +: 2]);
    res8        = r.ctrl[CTRL_RES8_BIT];
    osr_now     = res8 ? 16'(OSR_L) : 16'(OSR_H);
    sample_tick = 1'b0;
    publish     = 1'b0;
    mux_change  = 1'b0;
    done_ev     = 2'b00;
    wval        = 32'h0000_0000;
    c0 = '0;
    c1 = '0;
    c2 = '0;
    c3 = '0;

    // bus handshakes: address and data accepted in either order
    if (s_axi_awvalid && !r.aw_ok) begin
      next_r.aw_ok   = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.w_ok) begin
      next_r.w_ok   = 1'b1;
      next_r.w_data = s_axi_wdata;
      next_r.w_strb = s_axi_wstrb;
    end
    do_wr = r.aw_ok && r.w_ok && !r.bvalid;
    do_rd = s_axi_arvalid && !r.rvalid;
    result_rd = (do_rd && s_axi_araddr == ADDR_RESULT) || dma_read;
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end

    start_ev = conversion_start_pulse;
    if (do_wr) begin
      next_r.aw_ok  = 1'b0;
      next_r.w_ok   = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp  = addr_known(r.aw_addr) ? 2'b00 : 2'b10;
      if (r.aw_addr == ADDR_CTRL) begin
        wval = merge_bytes(r.ctrl, r.w_data, r.w_strb);
        start_ev = start_ev || wval[CTRL_START_BIT];
        wval[CTRL_START_BIT] = 1'b0;
        next_r.ctrl = wval;
      end else if (r.aw_addr == ADDR_IRQ_MK) begin
        next_r.irq_mk = r.w_data[1:0];
      end else if (r.aw_addr == ADDR_DIV) begin
        next_r.div = 16'(merge_bytes({16'h0000, r.div}, r.w_data, r.w_strb));
      end
    end

    // input selection change restarts validity count
    if (next_r.ctrl[CTRL_MUX_LSB +: 4] != r.mux_sel) begin
      mux_change     = 1'b1;
      next_r.mux_sel = next_r.ctrl[CTRL_MUX_LSB +: 4];
    end

    // ----------------------------------------------------------------
    // sinc^4 decimator: four integrators at modulator rate
    // ----------------------------------------------------------------
    next_r.conv_reset = 1'b0;
    if (r.state != ST_STANDBY) begin
      next_r.integ[0] = r.integ[0] + ACC_W'(mod_bit);
      next_r.integ[1] = r.integ[1] + r.integ[0];
      next_r.integ[2] = r.integ[2] + r.integ[1];
      next_r.integ[3] = r.integ[3] + r.integ[2];
      if (r.osr_cnt + 16'h0001 >= osr_now || r.osr_cnt + 16'h0001 >= r.div + osr_now) begin
        next_r.osr_cnt = 16'h0000;
        sample_tick = (r.osr_cnt + 16'h0001 >= osr_now);
      end else begin
        next_r.osr_cnt = r.osr_cnt + 16'h0001;
      end
    end

    // four-stage comb: each word spans four decimated samples
    if (sample_tick) begin
      c0 = r.integ[3] - r.comb_d[0];
      c1 = c0 - r.comb_d[1];
      c2 = c1 - r.comb_d[2];
      c3 = c2 - r.comb_d[3];
      next_r.comb_d[0] = r.integ[3];
      next_r.comb_d[1] = c0;
      next_r.comb_d[2] = c1;
      next_r.comb_d[3] = c2;
      if (r.conv_cnt != 3'(PRIME_SAMPLES)) begin
        next_r.conv_cnt = r.conv_cnt + 3'd1;
      end
      if (r.valid_cnt != 3'(PRIME_SAMPLES)) begin
        next_r.valid_cnt = r.valid_cnt + 3'd1;
      end
    end
    if (mux_change) begin
      next_r.valid_cnt = 3'd0;
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    case (r.state)
      ST_STANDBY: begin
        if (start_ev) begin
          next_r.state    = ST_RUN;
          next_r.conv_cnt = 3'd0;
          next_r.osr_cnt  = 16'h0000;
          next_r.integ    = '0;
          next_r.comb_d   = '0;
        end
      end
      ST_RUN: begin
        // start events ignored here
        if (sample_tick && r.conv_cnt >= 3'(PRIME_SAMPLES - 1)
            && (r.valid_cnt >= 3'(PRIME_SAMPLES - 1)) && !mux_change) begin
          publish = 1'b1;
          if (mode == MODE_SINGLE) begin
            next_r.state = ST_WAIT_RD;
          end else if (mode == MODE_CONT) begin
            next_r.conv_cnt = 3'(PRIME_SAMPLES - 1);
          end else begin
            next_r.conv_cnt   = 3'd0;
            next_r.integ      = '0;
            next_r.comb_d     = '0;
            next_r.osr_cnt    = 16'h0000;
            next_r.conv_reset = 1'b1;
          end
        end
      end
      ST_WAIT_RD: begin
        if (result_rd) begin
          next_r.state = ST_STANDBY;
        end
      end
      default: begin
        next_r.state = ST_STANDBY;
      end
    endcase

    if (publish) begin
      next_r.result = res8 ? scale_word(c3, SH_L, RES_LO_BITS)
                           : scale_word(c3, SH_H, RES_HI_BITS);
      done_ev[IRQ_DONE_BIT] = 1'b1;
      done_ev[IRQ_OVR_BIT]  = r.done && !result_rd;
    end

    // done flag: set wins over the clearing read
    if (publish) begin
      next_r.done = 1'b1;
    end else if (result_rd) begin
      next_r.done = 1'b0;
    end
    next_r.dma_req = next_r.done && r.ctrl[CTRL_RTE_BIT];

    if (do_wr && r.aw_addr == ADDR_IRQ_ST) begin
      next_r.irq_st = r.irq_st & ~r.w_data[1:0];
    end
    next_r.irq_st = next_r.irq_st | done_ev;
    next_r.irq    = |(next_r.irq_st & next_r.irq_mk);

    // read data path
    if (do_rd) begin
      next_r.rvalid = 1'b1;
      next_r.rresp  = 2'b00;
      if (s_axi_araddr == ADDR_CTRL) begin
        next_r.rdata = r.ctrl;
      end else if (s_axi_araddr == ADDR_STATUS) begin
        next_r.rdata = {28'h000_0000, r.valid_cnt == 3'(PRIME_SAMPLES), r.state, r.done};
      end else if (s_axi_araddr == ADDR_RESULT) begin
        next_r.rdata = {20'h0_0000, r.result};
      end else if (s_axi_araddr == ADDR_IRQ_ST) begin
        next_r.rdata = {30'h0, r.irq_st};
      end else if (s_axi_araddr == ADDR_IRQ_MK) begin
        next_r.rdata = {30'h0, r.irq_mk};
      end else if (s_axi_araddr == ADDR_DIV) begin
        next_r.rdata = {16'h0000, r.div};
      end else begin
        next_r.rdata = 32'h0000_0000;
        next_r.rresp = 2'b10;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r        <= '0;
      r.state  <= ST_STANDBY;
      r.ctrl   <= CTRL_RESET;
      r.div    <= DIV_RESET;
      r.irq_st <= IRQ_RESET;
      r.irq_mk <= IRQ_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flops; the three ready outputs are inverted flops
  // ----------------------------------------------------------------
  assign conversion_done_flag = r.done;
  assign irq                  = r.irq;
  assign dma_req              = r.dma_req;
  assign mux_sel              = r.mux_sel;
  assign conv_reset           = r.conv_reset;
  assign result_word          = r.result;
  assign s_axi_awready        = !r.aw_ok;
  assign s_axi_wready         = !r.w_ok;
  assign s_axi_bvalid         = r.bvalid;
  assign s_axi_bresp          = r.bresp;
  assign s_axi_arready        = !r.rvalid;
  assign s_axi_rvalid         = r.rvalid;
  assign s_axi_rdata          = r.rdata;
  assign s_axi_rresp          = r.rresp;

endmodule : sdas_seq

// ==== sdas_chk_assertions.sv ====
// checker: bus handshake and conversion flag properties of the sequencer
`timescale 1ns/1ps
module sdas_chk
  import sdas_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        dma_read,
  input wire logic        conversion_done_flag,
  input wire logic        dma_req,
  input wire logic [3:0]  mux_sel,
  input wire logic        conv_reset,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // the flag may only fall once a result read has been seen
  a_done_held: assert property (conversion_done_flag && !dma_read && !$past(dma_read)
    && !s_axi_arvalid && !s_axi_rvalid && !$past(s_axi_rvalid) |=> conversion_done_flag)
    else $error("done flag dropped without a read");
  a_dma_route: assert property (dma_req |-> conversion_done_flag || $past(conversion_done_flag))
    else $error("dma request without a result");
  a_conv_pulse: assert property (conv_reset |=> !conv_reset)
    else $error("converter reset longer than one cycle");
  a_mux_write: assert property ($changed(mux_sel) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("mux selection moved without a write");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address accepted while data pending");
  a_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > ADDR_DIV
    |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_wr_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
endmodule : sdas_chk

bind sdas_seq sdas_chk u_chk (.*);

// ==== sdas_dma_model.sv ====
// model of the dma side: reads a routed result after a set delay
`timescale 1ns/1ps
module sdas_dma_model (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       en,
  input wire logic [7:0] delay,
  input wire logic       dma_req,
  output logic           dma_read
);
  logic [7:0] cnt;
  logic       served;
  // served stops a second read while the request is still falling
  always_ff @(posedge aclk) begin
    if (!aresetn || !en || !dma_req) begin
      cnt      <= 8'h00;
      served   <= 1'b0;
      dma_read <= 1'b0;
    end else if (dma_read) begin
      dma_read <= 1'b0;
      served   <= 1'b1;
    end else if (!served && cnt >= delay) begin
      dma_read <= 1'b1;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule : sdas_dma_model

// ==== tb.sv ====
// testbench: register bus, modes, flag and interrupt behaviour of the sequencer
`timescale 1ns/1ps
module tb;
  import sdas_pkg::*;
  localparam int OH = 8;
  localparam int OL = 4;
  logic aclk = 0, aresetn = 0, mod_bit = 0, start_p = 0, en = 0, dma_read;
  logic [7:0] dly = 0, awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic [3:0] wstrb = 0, mux;
  logic done, irq, dma_req, awready, wready, bvalid, arready, rvalid, crst;
  logic [11:0] res;
  logic [1:0] bresp, rresp, rs;
  int mismatches = 0, n_tests = 0, n_dma = 0, n_crst = 0, cnt, c12;
  logic [41:0] rows [7] = '{{ADDR_CTRL, CTRL_RESET, 2'b00}, {ADDR_STATUS, 32'h0000_0000, 2'b00},
    {ADDR_RESULT, 32'h0000_0000, 2'b00}, {ADDR_IRQ_ST, 32'h0000_0000, 2'b00},
    {ADDR_IRQ_MK, 32'h0000_0000, 2'b00}, {ADDR_DIV, {16'h0000, DIV_RESET}, 2'b00},
    {8'h18, 32'h0000_0000, 2'b10}};
  always #2 aclk = ~aclk;
  always @(posedge aclk) begin
    mod_bit <= ~mod_bit ^ n_tests[0];
    if (dma_read === 1'b1) n_dma++;
    if (crst === 1'b1) n_crst++;
  end
  sdas_seq #(.OSR_H(OH), .OSR_L(OL)) dut (.aclk(aclk), .aresetn(aresetn), .mod_bit(mod_bit),
    .conversion_start_pulse(start_p), .dma_read(dma_read), .conversion_done_flag(done),
    .irq(irq), .dma_req(dma_req), .mux_sel(mux), .conv_reset(crst), .result_word(res),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  sdas_dma_model u_dma (.aclk(aclk), .aresetn(aresetn), .en(en), .delay(dly),
    .dma_req(dma_req), .dma_read(dma_read));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // handshakes are judged on settled values before the edge, released just after it
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    int i;
    @(posedge aclk);
    {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, 4'hf, 3'b111};
    for (i = 0; i < 50; i++) begin
      @(negedge aclk);
      {ha, hw, hb} = {awvalid && awready, wvalid && wready, bvalid};
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) begin
        bready <= 1'b0;
        break;
      end
    end
    if (i == 50) begin
      mismatches++;
      complete_run();
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, hb;
    int i;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    for (i = 0; i < 50; i++) begin
      @(negedge aclk);
      {ha, hb, d, r} = {arvalid && arready, rvalid, rdata, rresp};
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
      if (hb) begin
        rready <= 1'b0;
        break;
      end
    end
    if (i == 50) begin
      mismatches++;
      complete_run();
    end
  endtask : axi_rd
  task automatic rst;
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    n_dma = 0;
    n_crst = 0;
  endtask : rst
  task automatic wait_done(output int c);
    for (c = 0; c < 1000 && done !== 1'b1; c++) @(negedge aclk);
    if (c == 1000) begin
      mismatches++;
      complete_run();
    end
  endtask : wait_done
  initial begin
    rst();
    foreach (rows[k]) begin
      axi_rd(rows[k][41:34], rd, rs);
      check("reg", rd, rows[k][33:2]);
      check("resp", rs, rows[k][1:0]);
    end
    // a second pulse in mid-run must neither restart nor add a run
    @(posedge aclk) start_p <= 1'b1;
    @(posedge aclk) start_p <= 1'b0;
    repeat (5) @(posedge aclk);
    start_p <= 1'b1;
    @(posedge aclk) start_p <= 1'b0;
    wait_done(cnt);
    c12 = cnt + 7;
    check("lat12", c12 > 3 * OH, 1);
    check("norestart", cnt < 4 * OH - 2, 1);
    repeat (20) @(negedge aclk);
    check("held", done, 1);
    axi_rd(ADDR_STATUS, rd, rs);
    check("stat", rd[2:0], 3'b101);
    @(negedge aclk) check("irqmask", irq, 0);
    axi_rd(ADDR_IRQ_ST, rd, rs);
    check("irqst", rd[1:0], 2'b01);
    axi_wr(ADDR_IRQ_MK, 32'h0000_0001);
    repeat (2) @(negedge aclk);
    check("irqon", irq, 1);
    axi_wr(ADDR_IRQ_ST, 32'h0000_0001);
    repeat (2) @(negedge aclk);
    check("irqclr", irq, 0);
    axi_rd(ADDR_RESULT, rd, rs);
    check("result", rd[11:0] >= 12'h7ff && rd[11:0] <= 12'h800, 1);
    check("resword", res >= 12'h7ff && res <= 12'h800, 1);
    repeat (2) @(negedge aclk);
    check("clr", done, 0);
    repeat (4 * OH + 20) @(negedge aclk);
    check("idle", done, 0);
    axi_rd(ADDR_STATUS, rd, rs);
    check("standby", rd[2:0], 3'b000);
    axi_wr(ADDR_CTRL, 32'h0000_0009);
    wait_done(cnt);
    check("lat8", cnt > 3 * OL && cnt < c12, 1);
    axi_rd(ADDR_RESULT, rd, rs);
    for (int m = 1; m < 4; m++) begin
      rst();
      en <= 1'b1;
      dly <= (m == 1) ? 8'h06 : 8'h00;
      axi_wr(ADDR_CTRL, 32'h0000_0101 | (m << 1));
      if (m == 1) begin
        repeat (30) @(posedge aclk);
        axi_wr(ADDR_CTRL, 32'h0000_0152);
        repeat (2) @(negedge aclk);
        check("mux", mux, 4'h5);
        axi_rd(ADDR_STATUS, rd, rs);
        check("valid", rd[3], 0);
      end
      repeat (300) @(posedge aclk);
      check("reads", n_dma > 2, 1);
      check("creset", n_crst > 0, m != 2);
    end
    rst();
    @(negedge aclk) check("rst", done, 0);
    complete_run();
  end
endmodule : tb
